// [src/drive_log_cmd.sv]
// Health query, off-line switch and extended log read.
// Assumes task-file inputs come from host logic on sys_clk, command strobe
// one cycle long while the latched register values stand beside it.
`include "drive_log_consts.svh"
module drive_log_cmd #(
  parameter int CYC_PER_MS = `CYC_PER_MS,
  parameter int MS_PER_HOUR = `MS_PER_HOUR
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] features_reg,
  input wire logic [7:0] sector_count_reg,
  input wire logic [7:0] sector_count_prev,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_mid_prev,
  input wire logic [15:0] cylinder_pair,
  input wire logic status_rd,
  input wire logic data_ack,
  input wire logic nv_save_done,
  input wire logic attr_save_event,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output logic busy_q,
  output logic drq_q,
  output logic intrq_q,
  output logic abort_q,
  output logic cyl_load_q,
  output logic [15:0] cyl_out_q,
  output logic data_valid_q,
  output logic [7:0] data_byte_q,
  output logic nv_save_req_q,
  output logic offline_start_q
);
  import drive_log_pkg::*;

  if (CYC_PER_MS < 1 || MS_PER_HOUR < 1) begin : g_bad_counts
    $error("uptime counts must be at least one");
  end

  // ============================================================
  // Shared decoding
  // Directory sector count of one log address, also the range check.
  function automatic logic [15:0] dir_count(input logic [7:0] addr);
    if (addr == `LOG_DIRECTORY) begin
      dir_count = 16'h1;
    end else if (addr == `LOG_ERROR_EXT) begin
      dir_count = `ERR_LOG_SECTORS;
    end else if (addr == `LOG_SELFTEST_EXT) begin
      dir_count = `SELFTEST_SECTORS;
    end else if (addr >= `LOG_HOST_FIRST && addr <= `LOG_HOST_LAST) begin
      dir_count = `HOST_LOG_SECTORS;
    end else begin
      dir_count = 16'h0;
    end
  endfunction

  function automatic logic is_legacy(input logic [7:0] addr);
    is_legacy = (addr == 8'h01) || (addr == 8'h02) ||
                (addr == 8'h06) || (addr == 8'h09);
  endfunction

  // ============================================================
  // State
  cmd_state_t state_q;
  logic offline_en_q;
  logic predict_q;
  logic [7:0] log_addr_q;
  logic [15:0] sector_q;
  logic [15:0] remain_q;
  logic start_q;
  logic [7:0] rec_cmd_q [`ERR_RECORDS];
  logic [7:0] rec_err_q [`ERR_RECORDS];
  logic [31:0] rec_ts_q [`ERR_RECORDS];
  logic [7:0] wr_ptr_q;
  logic [7:0] err_index_q;
  logic [15:0] err_count_q;
  logic [31:0] ms;
  logic [15:0] hours;
  logic offline_tick;
  logic [9:0] offset;
  logic [7:0] content;
  logic xfer_done;
  logic [15:0] log_size;
  logic [15:0] req_offset;
  logic log_event;

  assign log_size = dir_count(lba_low);
  assign req_offset = {lba_mid_prev, lba_mid};
  // Bad-command causes are never logged.
  assign log_event = reg_wr && reg_addr == `REG_ERR_LOG &&
                     reg_wdata[18:16] <= 3'(ERR_WFAULT);

  uptime_keeper #(
    .CYC_PER_MS(CYC_PER_MS),
    .MS_PER_HOUR(MS_PER_HOUR)
  ) u_uptime (
    .sys_clk(sys_clk),
    .reset(reset),
    .offline_en(offline_en_q),
    .ms_q(ms),
    .hours_q(hours),
    .offline_tick_q(offline_tick)
  );

  sector_streamer u_stream (
    .sys_clk(sys_clk),
    .reset(reset),
    .start(start_q),
    .csum_en(log_addr_q == `LOG_ERROR_EXT),
    .content(content),
    .data_ack(data_ack),
    .offset_q(offset),
    .data_valid_q(data_valid_q),
    .data_byte_q(data_byte_q),
    .done_q(xfer_done)
  );

  // ============================================================
  // Log content for the current sector and byte offset
  // Host and self-test logs read zeros; nothing writes them here.
  always_comb begin
    logic [7:0] dir_addr;
    logic [15:0] cnt;
    logic [1:0] quarter;
    logic [9:0] rel;
    logic [15:0] rec_wide;
    logic [7:0] rec;
    dir_addr = 8'h0;
    cnt = 16'h0;
    quarter = 2'h0;
    rel = 10'h0;
    rec_wide = 16'h0;
    rec = 8'h0;
    content = 8'h0;
    if (log_addr_q == `LOG_DIRECTORY && sector_q == 16'h0) begin
      dir_addr = offset[8:1];
      cnt = (dir_addr == 8'h0) ? `GP_LOG_VERSION : dir_count(dir_addr);
      content = offset[0] ? cnt[15:8] : cnt[7:0];
    end else if (log_addr_q == `LOG_ERROR_EXT) begin
      if (offset >= `REC_FIRST && offset < `ERR_COUNT_BYTE) begin
        if (offset < `REC_FIRST + `REC_BYTES) begin
          quarter = 2'h0;
        end else if (offset < `REC_FIRST + 10'h2 * `REC_BYTES) begin
          quarter = 2'h1;
        end else if (offset < `REC_FIRST + 10'h3 * `REC_BYTES) begin
          quarter = 2'h2;
        end else begin
          quarter = 2'h3;
        end
        rel = offset - `REC_FIRST - 10'(quarter) * `REC_BYTES;
        rec_wide = {sector_q[13:0], quarter};
        rec = rec_wide[7:0];
        if (rel == `REC_CMD_BYTE) begin
          content = rec_cmd_q[rec];
        end else if (rel >= `REC_TS_BYTE && rel < `REC_TS_BYTE + 10'h4) begin
          content = 8'(rec_ts_q[rec] >> (8 * (rel - `REC_TS_BYTE)));
        end else if (rel == `REC_ERR_BYTE) begin
          content = rec_err_q[rec];
        end
      end else if (sector_q == 16'h0) begin
        case (offset)
          10'h000: content = `ERR_LOG_VERSION;
          10'h002: content = err_index_q;
          `ERR_COUNT_BYTE: content = err_count_q[7:0];
          `ERR_COUNT_BYTE + 10'h1: content = err_count_q[15:8];
          default: content = 8'h0;
        endcase
      end
    end
  end

  // ============================================================
  // Error record store, filled by firmware through the register port
  // Every logged error enters here whatever its address width.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `ERR_RECORDS; i++) begin
        rec_cmd_q[i] <= 8'h0;
        rec_err_q[i] <= 8'h0;
        rec_ts_q[i] <= 32'h0;
      end
      wr_ptr_q <= 8'h0;
      err_index_q <= 8'h0;
      err_count_q <= 16'h0;
    end else if (log_event) begin
      rec_cmd_q[wr_ptr_q] <= reg_wdata[7:0];
      rec_err_q[wr_ptr_q] <= reg_wdata[15:8];
      rec_ts_q[wr_ptr_q] <= ms;
      err_index_q <= wr_ptr_q;
      wr_ptr_q <= wr_ptr_q + 8'h1;
      if (err_count_q != 16'hffff) begin
        err_count_q <= err_count_q + 16'h1;
      end
    end
  end

  // ============================================================
  // Register port: read data stand one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata_q <= 32'h0;
      predict_q <= 1'b0;
    end else begin
      reg_rdata_q <= 32'h0;
      if (reg_wr && reg_addr == `REG_PREDICT) begin
        predict_q <= reg_wdata[0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `REG_PREDICT: reg_rdata_q <= {31'h0, predict_q};
          `REG_OFFLINE: reg_rdata_q <= {31'h0, offline_en_q};
          `REG_ERR_COUNT: reg_rdata_q <= {16'h0, err_count_q};
          `REG_ERR_INDEX: reg_rdata_q <= {24'h0, err_index_q};
          `REG_HOURS: reg_rdata_q <= {16'h0, hours};
          default: reg_rdata_q <= 32'h0;
        endcase
      end
    end
  end

  // ============================================================
  // Attribute saves and the off-line collection start
  // A save may be asked for at power events even with collection off.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nv_save_req_q <= 1'b0;
      offline_start_q <= 1'b0;
    end else begin
      offline_start_q <= offline_tick;
      if (cmd_wr && cmd_code == `OP_HEALTH && !busy_q &&
          cylinder_pair == `HEALTH_SIGNATURE &&
          features_reg == `SUB_RETURN_STATUS) begin
        nv_save_req_q <= 1'b1;
      end else if (attr_save_event && state_q == ST_IDLE) begin
        nv_save_req_q <= 1'b1;
      end else if (nv_save_done) begin
        nv_save_req_q <= 1'b0;
      end
    end
  end

  // ============================================================
  // Command sequencer
  // Commands written while busy are ignored; the host must wait for idle.
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      drq_q <= 1'b0;
      intrq_q <= 1'b0;
      abort_q <= 1'b0;
      cyl_load_q <= 1'b0;
      cyl_out_q <= 16'h0;
      offline_en_q <= 1'b0;
      log_addr_q <= 8'h0;
      sector_q <= 16'h0;
      remain_q <= 16'h0;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      cyl_load_q <= 1'b0;
      // Clear first so a completion in the same cycle wins.
      if (status_rd) begin
        intrq_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr && cmd_code == `OP_HEALTH) begin
            busy_q <= 1'b1;
            intrq_q <= 1'b0;
            abort_q <= 1'b0;
            state_q <= ST_DONE;
            if (cylinder_pair != `HEALTH_SIGNATURE) begin
              abort_q <= 1'b1;
            end else if (features_reg == `SUB_RETURN_STATUS) begin
              state_q <= ST_SAVE;
            end else if (features_reg == `SUB_AUTO_OFFLINE) begin
              if (sector_count_reg == `OFFLINE_OFF) begin
                offline_en_q <= 1'b0;
              end else if (sector_count_reg == `OFFLINE_ON) begin
                offline_en_q <= 1'b1;
              end
            end else begin
              abort_q <= 1'b1;
            end
          end else if (cmd_wr && cmd_code == `OP_READ_LOG_EXT) begin
            busy_q <= 1'b1;
            intrq_q <= 1'b0;
            abort_q <= 1'b0;
            log_addr_q <= lba_low;
            sector_q <= req_offset;
            remain_q <= {sector_count_prev, sector_count_reg};
            state_q <= ST_DONE;
            if (is_legacy(lba_low)) begin
              abort_q <= 1'b1;
            end else if (req_offset >= log_size) begin
              abort_q <= 1'b1;
            end else if ({sector_count_prev, sector_count_reg} != 16'h0) begin
              drq_q <= 1'b1;
              start_q <= 1'b1;
              state_q <= ST_XFER;
            end
          end
        end
        ST_SAVE: begin
          if (nv_save_done) begin
            state_q <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          cyl_out_q <= predict_q ? `HEALTH_FAILING : `HEALTH_SIGNATURE;
          cyl_load_q <= 1'b1;
          state_q <= ST_DONE;
        end
        ST_XFER: begin
          if (xfer_done) begin
            intrq_q <= 1'b1;
            if (remain_q == 16'h1) begin
              busy_q <= 1'b0;
              drq_q <= 1'b0;
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          remain_q <= remain_q - 16'h1;
          sector_q <= sector_q + 16'h1;
          start_q <= 1'b1;
          state_q <= ST_XFER;
        end
        ST_DONE: begin
          busy_q <= 1'b0;
          intrq_q <= 1'b1;
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// [src/drive_log_consts.svh]
// Offsets, values and timing of the health and log commands.
// Assumes a 50 MHz sys_clk and an 8-bit task-file path from the host.
//
// Summary of operation
// - Health query, no failure: cylinders 4Fh, C2h.
// - Health query, failure predicted: cylinders F4h, 2Ch.
// - Health query raises busy, saves attributes, evaluates.
// - Off-line switch with count 00h disables collection.
// - Off-line switch with count F8h enables; others vendor.
// - Attribute saves still allowed while collection disabled.
// - Enabled collection starts every 24 power-on hours.
// - Log read sends sectors, interrupt per block.
// - Sixteen-bit count; transfer starts at requested offset.
// - Decode directory, error log, self-test, host logs.
// - Legacy log addresses 01h 02h 06h 09h abort.
// - Directory starts with version word 0001h.
// - Directory entry for address at twice address.
// - Host logs 80h-9Fh are sixteen sectors each.
// - Extended error log spans 64 sectors.
// - Log media errors, never rejected commands.
// - Older 28-bit entries also land in extended log.
// - Sector zero header, four records, count, checksum.
// - Error log version byte is 01h.
// - Index names newest record, zero when empty.
// - Checksum byte makes the 512-byte sum zero.
// - Records fill circularly; unused records read zero.
// - Non-data commands: busy, act, drop busy, interrupt.
`ifndef DRIVE_LOG_CONSTS_SVH
`define DRIVE_LOG_CONSTS_SVH

// ============================================================
// Command codes and values
`define OP_HEALTH 8'hb0
`define OP_READ_LOG_EXT 8'h2f
`define SUB_RETURN_STATUS 8'hda
`define SUB_AUTO_OFFLINE 8'hdb
`define HEALTH_SIGNATURE 16'hc24f
`define HEALTH_FAILING 16'h2cf4
`define OFFLINE_OFF 8'h00
`define OFFLINE_ON 8'hf8

// ============================================================
// Log addresses and sizes
`define LOG_DIRECTORY 8'h00
`define LOG_ERROR_EXT 8'h03
`define LOG_SELFTEST_EXT 8'h07
`define LOG_HOST_FIRST 8'h80
`define LOG_HOST_LAST 8'h9f
`define GP_LOG_VERSION 16'h0001
`define HOST_LOG_SECTORS 16'h0010
`define ERR_LOG_SECTORS 16'h0040
`define SELFTEST_SECTORS 16'h0001
`define ERR_LOG_VERSION 8'h01
`define ERR_RECORDS 256
`define REC_BYTES 10'h07c
`define REC_FIRST 10'h004
`define REC_CMD_BYTE 10'h054
`define REC_TS_BYTE 10'h056
`define REC_ERR_BYTE 10'h05b
`define ERR_COUNT_BYTE 10'h1f4
`define LAST_BYTE 10'h1ff

// ============================================================
// Register port offsets
`define REG_PREDICT 8'h00
`define REG_OFFLINE 8'h04
`define REG_ERR_COUNT 8'h08
`define REG_ERR_INDEX 8'h0c
`define REG_HOURS 8'h10
`define REG_ERR_LOG 8'h14

// ============================================================
// Timing
`define CLK_PERIOD_NS 20
`define MS_IN_NS 1000000
`define CYC_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define MS_PER_HOUR 3600000
`define OFFLINE_HOURS 24

`endif

// [src/drive_log_pkg.sv]
// Types shared by the health and log command logic.
// Assumes nothing beyond a SystemVerilog compiler.
package drive_log_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_SAVE = 6'h02,
    ST_EVAL = 6'h04,
    ST_XFER = 6'h08,
    ST_DONE = 6'h10,
    ST_NEXT = 6'h20
  } cmd_state_t;

  // Error causes reported by firmware; the last three are never logged.
  typedef enum logic [2:0] {
    ERR_UNC = 3'h0,
    ERR_IDNF = 3'h1,
    ERR_SERVO = 3'h2,
    ERR_WFAULT = 3'h3,
    ERR_BAD_OPCODE = 3'h4,
    ERR_BAD_PARAM = 3'h5,
    ERR_BAD_ADDR = 3'h6
  } err_kind_t;
endpackage

// [src/uptime_keeper.sv]
// Millisecond and power-on hour timekeeping with the off-line interval tick.
// Assumes it restarts with power-on reset.
`include "drive_log_consts.svh"
module uptime_keeper #(
  parameter int CYC_PER_MS = `CYC_PER_MS,
  parameter int MS_PER_HOUR = `MS_PER_HOUR
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic offline_en,
  output logic [31:0] ms_q,
  output logic [15:0] hours_q,
  output logic offline_tick_q
);
  logic [31:0] cyc_q;
  logic [31:0] ms_in_hour_q;
  logic [4:0] hours_since_q;

  // One counter chain; the interval only advances while collection is on.
  always_ff @(posedge sys_clk) begin
    offline_tick_q <= 1'b0;
    if (reset) begin
      cyc_q <= 32'h0;
      ms_q <= 32'h0;
      ms_in_hour_q <= 32'h0;
      hours_q <= 16'h0;
      hours_since_q <= 5'h0;
    end else if (cyc_q == 32'(CYC_PER_MS - 1)) begin
      cyc_q <= 32'h0;
      ms_q <= ms_q + 32'h1;
      if (ms_in_hour_q == 32'(MS_PER_HOUR - 1)) begin
        ms_in_hour_q <= 32'h0;
        hours_q <= hours_q + 16'h1;
        if (!offline_en) begin
          hours_since_q <= 5'h0;
        end else if (hours_since_q == 5'(`OFFLINE_HOURS - 1)) begin
          hours_since_q <= 5'h0;
          offline_tick_q <= 1'b1;
        end else begin
          hours_since_q <= hours_since_q + 5'h1;
        end
      end else begin
        ms_in_hour_q <= ms_in_hour_q + 32'h1;
      end
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end
endmodule

// [src/sector_streamer.sv]
// Sends one 512-byte sector, one byte per host acknowledge, with checksum.
// Assumes the parent feeds the byte at offset_q combinationally.
`include "drive_log_consts.svh"
module sector_streamer (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic start,
  input wire logic csum_en,
  input wire logic [7:0] content,
  input wire logic data_ack,
  output logic [9:0] offset_q,
  output logic data_valid_q,
  output logic [7:0] data_byte_q,
  output logic done_q
);
  logic [7:0] sum_q;
  logic active_q;
  logic [7:0] byte_d;

  // The last byte replaces content with the two's complement of the sum.
  always_comb begin
    byte_d = content;
    if (csum_en && offset_q == `LAST_BYTE) begin
      byte_d = 8'h0 - sum_q;
    end
  end

  // Fetch a byte, hold it until acknowledged, then step the offset.
  always_ff @(posedge sys_clk) begin
    done_q <= 1'b0;
    if (reset) begin
      offset_q <= 10'h0;
      sum_q <= 8'h0;
      active_q <= 1'b0;
      data_valid_q <= 1'b0;
      data_byte_q <= 8'h0;
    end else if (start) begin
      offset_q <= 10'h0;
      sum_q <= 8'h0;
      active_q <= 1'b1;
      data_valid_q <= 1'b0;
    end else if (active_q && !data_valid_q) begin
      data_byte_q <= byte_d;
      data_valid_q <= 1'b1;
      sum_q <= sum_q + byte_d;
    end else if (data_valid_q && data_ack) begin
      data_valid_q <= 1'b0;
      if (offset_q == `LAST_BYTE) begin
        active_q <= 1'b0;
        done_q <= 1'b1;
      end else begin
        offset_q <= offset_q + 10'h1;
      end
    end
  end
endmodule

// [verif/drive_log_cmd_sva.sv]
// Port assertions for the health and log command block.
// Assumes it is bound to drive_log_cmd; one clock, synchronous reset.
`include "drive_log_consts.svh"
module drive_log_sva (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] features_reg,
  input wire logic [7:0] lba_low,
  input wire logic [7:0] lba_mid,
  input wire logic [7:0] lba_mid_prev,
  input wire logic [15:0] cylinder_pair,
  input wire logic data_ack,
  input wire logic busy_q,
  input wire logic drq_q,
  input wire logic intrq_q,
  input wire logic abort_q,
  input wire logic cyl_load_q,
  input wire logic [15:0] cyl_out_q,
  input wire logic data_valid_q,
  input wire logic nv_save_req_q
);
  // ============================================================
  // Accepted commands
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic hc;
  logic lc;
  // Strobes while busy are ignored, so only idle strobes count.
  assign hc = cmd_wr && !busy_q && cmd_code == `OP_HEALTH;
  assign lc = cmd_wr && !busy_q && cmd_code == `OP_READ_LOG_EXT;

  // ============================================================
  // Properties
  property p_take; hc || lc |=> busy_q; endproperty
  a_take: assert property (p_take) else $error("busy missing");
  property p_done; $fell(busy_q) |-> intrq_q; endproperty
  a_done: assert property (p_done) else $error("no interrupt");
  property p_save; hc && features_reg == `SUB_RETURN_STATUS &&
    cylinder_pair == `HEALTH_SIGNATURE |=> nv_save_req_q; endproperty
  a_save: assert property (p_save) else $error("no save");
  property p_res; cyl_load_q |-> (cyl_out_q == `HEALTH_SIGNATURE ||
    cyl_out_q == `HEALTH_FAILING) ##1 (!busy_q && intrq_q); endproperty
  a_res: assert property (p_res) else $error("bad result");
  property p_sig; hc && cylinder_pair != `HEALTH_SIGNATURE
    |-> ##2 (abort_q && intrq_q && !busy_q); endproperty
  a_sig: assert property (p_sig) else $error("sig accepted");
  property p_leg; lc && lba_low inside {8'h01, 8'h02, 8'h06, 8'h09}
    |-> ##2 (abort_q && intrq_q); endproperty
  a_leg: assert property (p_leg) else $error("legacy accepted");
  property p_rng; lc && lba_low[7:5] == 3'h4 &&
    {lba_mid_prev, lba_mid} >= 16'h0010 |-> ##2 abort_q; endproperty
  a_rng: assert property (p_rng) else $error("range accepted");
  property p_drq; data_valid_q |-> drq_q && busy_q; endproperty
  a_drq: assert property (p_drq) else $error("data without drq");
  property p_next; $rose(intrq_q) && drq_q |-> ##[1:3] data_valid_q;
  endproperty
  a_next: assert property (p_next) else $error("next block late");
  property p_ack; data_valid_q && data_ack |=> !data_valid_q; endproperty
  a_ack: assert property (p_ack) else $error("byte repeated");
endmodule

// [verif/ata_host_model.sv]
// Host adapter model: takes PIO bytes and reads status on interrupts.
// Assumes the stream handshake of drive_log_cmd.
module ata_host_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic slow,
  input wire logic data_valid_q,
  input wire logic [7:0] data_byte_q,
  input wire logic intrq_q,
  output logic data_ack,
  output logic status_rd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sec_q [512];
  int nbytes;
  int nint;
  int wait_q;
  // ============================================================
  // Byte intake; a slow host idles up to three cycles per byte.
  always @(posedge sys_clk) begin
    if (reset) begin
      data_ack <= 1'b0;
      nbytes <= 0;
      wait_q <= 0;
    end else if (data_valid_q && data_ack) begin
      sec_q[nbytes % 512] <= data_byte_q;
      nbytes <= nbytes + 1;
      data_ack <= 1'b0;
      wait_q <= slow ? $urandom_range(3, 0) : 0;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end else begin
      data_ack <= data_valid_q;
    end
  end
  // One status read per interrupt, which also clears it.
  always @(posedge sys_clk) begin
    if (reset) begin
      status_rd <= 1'b0;
      nint <= 0;
    end else if (intrq_q && !status_rd) begin
      status_rd <= 1'b1;
      nint <= nint + 1;
    end else begin
      status_rd <= 1'b0;
    end
  end
endmodule

// [verif/drive_log_cmd_tb_top.sv]
// Self-checking bench for the health and log command block.
// Assumes the host model and checker are compiled first.
`include "drive_log_consts.svh"
module drive_log_cmd_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, reset = 1, cmd_wr = 0, reg_wr = 0, reg_rd = 0;
  logic nv_save_done = 0, attr_save_event = 0, slow = 0;
  logic [7:0] cmd_code = 0, features_reg = 0, sector_count_reg = 0;
  logic [7:0] sector_count_prev = 0, lba_low = 0, lba_mid = 0;
  logic [7:0] lba_mid_prev = 0, reg_addr = 0;
  logic [15:0] cylinder_pair = 0, cyl_out_q;
  logic [31:0] reg_wdata = 0, reg_rdata_q, rd;
  logic busy_q, drq_q, intrq_q, abort_q, cyl_load_q, data_valid_q;
  logic nv_save_req_q, offline_start_q, data_ack, status_rd;
  logic [7:0] data_byte_q, e_cmd, e_err, la;
  logic [2:0] kind;
  int num_errors = 0, n_tests = 0, k, gap, db, di;
  logic [7:0] bad [8] = '{1, 2, 6, 9, 4, 8, 8'h0a, 8'ha0};

  drive_log_cmd #(.CYC_PER_MS(4), .MS_PER_HOUR(3)) dut_u (.*);
  ata_host_model host_u (.*);

  // ============================================================
  // Clock, firmware save responder and watchdog
  always #10 sys_clk = ~sys_clk;
  // Firmware acknowledges saves a cycle later.
  always @(posedge sys_clk) nv_save_done <= nv_save_req_q && !nv_save_done;
  // About eight times the expected run.
  initial begin
    #(20 * 80000);
    num_errors++;
    results();
  end

  // ============================================================
  // Tasks and expectations
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 d = reg_rdata_q;
  endtask
  // Issues one command, waits for busy to drop, then counts host traffic.
  task automatic issue(input logic [7:0] op, ft, input logic [15:0] cnt,
      input logic [7:0] a, input logic [15:0] off, cy);
    db = host_u.nbytes;
    di = host_u.nint;
    @(posedge sys_clk);
    cmd_wr <= 1;
    cmd_code <= op;
    features_reg <= ft;
    {sector_count_prev, sector_count_reg} <= cnt;
    lba_low <= a;
    {lba_mid_prev, lba_mid} <= off;
    cylinder_pair <= cy;
    @(posedge sys_clk);
    cmd_wr <= 0;
    #1;
    for (k = 0; k < 20000 && busy_q !== 1'b0; k++) @(posedge sys_clk) #1;
    repeat (3) @(posedge sys_clk);
    #1 db = host_u.nbytes - db;
    di = host_u.nint - di;
  endtask
  task automatic wait_start(output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while (offline_start_q !== 1'b1 && n < 400);
  endtask
  function automatic logic [7:0] dir_byte(input int b);
    if (b % 2) return 8'h00;
    if (b == 0 || b == 14) return 8'h01;
    if (b == 6) return 8'h40;
    return (b >= 256 && b < 320) ? 8'h10 : 8'h00;
  endfunction
  function automatic logic [7:0] sum8();
    logic [7:0] s = 0;
    for (int i = 0; i < 512; i++) s += host_u.sec_q[i];
    return s;
  endfunction

  // ============================================================
  // Main sequence
  initial begin
    void'($urandom(32'hbb3ea21c));
    repeat (6) @(posedge sys_clk);
    reset <= 0;
    reg_write(`REG_OFFLINE, 1);
    foreach (bad[i]) begin
      reg_read(bad[i] + 8'h40, rd);
      check(rd, 0);
    end
    issue(`OP_HEALTH, `SUB_RETURN_STATUS, 0, 0, 0, `HEALTH_SIGNATURE);
    check(cyl_out_q, `HEALTH_SIGNATURE);
    reg_write(`REG_PREDICT, 1);
    issue(`OP_HEALTH, `SUB_RETURN_STATUS, 0, 0, 0, `HEALTH_SIGNATURE);
    check({abort_q, cyl_out_q}, `HEALTH_FAILING);
    issue(`OP_HEALTH, `SUB_RETURN_STATUS, 0, 0, 0,
      `HEALTH_SIGNATURE ^ 16'($urandom_range(65535, 1)));
    check(abort_q, 1);
    issue(`OP_HEALTH, $urandom_range(217, 0), 0, 0, 0, `HEALTH_SIGNATURE);
    check(abort_q, 1);
    issue(`OP_HEALTH, `SUB_AUTO_OFFLINE, `OFFLINE_ON, 0, 0,
      `HEALTH_SIGNATURE);
    issue(`OP_HEALTH, `SUB_AUTO_OFFLINE, 8'h5a, 0, 0, `HEALTH_SIGNATURE);
    reg_read(`REG_OFFLINE, rd);
    check(rd, 1);
    wait_start(gap);
    wait_start(gap);
    check(gap, 24 * 4 * 3);
    issue(`OP_HEALTH, `SUB_AUTO_OFFLINE, `OFFLINE_OFF, 0, 0,
      `HEALTH_SIGNATURE);
    reg_read(`REG_OFFLINE, rd);
    check(rd, 0);
    wait_start(gap);
    check(gap, 400);
    attr_save_event <= 1;
    @(posedge sys_clk);
    attr_save_event <= 0;
    #1 check(nv_save_req_q, 1);
    for (int i = 0; i < 3; i++) begin
      e_cmd = $urandom;
      e_err = $urandom;
      kind = (i == 1) ? $urandom_range(6, 4) : $urandom_range(3, 0);
      reg_write(`REG_ERR_LOG, {13'h0, kind, e_err, e_cmd});
    end
    reg_read(`REG_ERR_COUNT, rd);
    check(rd, 2);
    slow <= 1;
    issue(`OP_READ_LOG_EXT, 0, 1, `LOG_ERROR_EXT, 0, 0);
    check({db[15:0], di[7:0]}, {16'd512, 8'd1});
    check(host_u.sec_q[0], `ERR_LOG_VERSION);
    check({host_u.sec_q[3], host_u.sec_q[2]}, 1);
    check({host_u.sec_q[212], host_u.sec_q[219]}, {e_cmd, e_err});
    check({host_u.sec_q[501], host_u.sec_q[500]}, 2);
    check(host_u.sec_q[336], 0);
    check(sum8(), 0);
    issue(`OP_READ_LOG_EXT, 0, 2, `LOG_ERROR_EXT, 62, 0);
    check({db[15:0], di[7:0], abort_q}, {16'd1024, 8'd2, 1'b0});
    check(sum8(), 0);
    issue(`OP_READ_LOG_EXT, 0, 0, `LOG_ERROR_EXT, 0, 0);
    check({db[15:0], abort_q}, 0);
    issue(`OP_READ_LOG_EXT, 0, 1, `LOG_ERROR_EXT, 16'h0100, 0);
    check(abort_q, 1);
    slow <= 0;
    issue(`OP_READ_LOG_EXT, 0, 1, `LOG_DIRECTORY, 0, 0);
    for (int i = 0; i < 512; i++) check(host_u.sec_q[i], dir_byte(i));
    la = 8'h80 + 8'($urandom_range(31, 0));
    issue(`OP_READ_LOG_EXT, 0, 1, la, 15, 0);
    check({db[15:0], sum8(), abort_q}, {16'd512, 9'h0});
    issue(`OP_READ_LOG_EXT, 0, 1, la, 16, 0);
    check(abort_q, 1);
    foreach (bad[i]) begin
      issue(`OP_READ_LOG_EXT, 0, 1, bad[i], 0, 0);
      check({db[7:0], abort_q}, 1);
    end
    results();
  end
endmodule

bind drive_log_cmd drive_log_sva chk_u (.*);
